// File: hdl/rcf_pkg.sv
// Constants, types and field layout of the reset cause flag register block
package rcf_pkg;

  localparam int unsigned RCF_ADDR_W = 12;
  localparam int unsigned RCF_FLAG_W = 8;

  localparam logic [11:0] RCF_OFS_FLAGS = 12'h000;
  localparam logic [11:0] RCF_OFS_STATUS = 12'h004;
  localparam logic [11:0] RCF_OFS_MASK = 12'h008;

  localparam int unsigned RCF_BIT_STK_OVF = 7;
  localparam int unsigned RCF_BIT_STK_UNF = 6;
  localparam int unsigned RCF_BIT_UNUSED = 5;
  localparam int unsigned RCF_BIT_WDT = 4;
  localparam int unsigned RCF_BIT_EXT_PIN = 3;
  localparam int unsigned RCF_BIT_INSTR = 2;
  localparam int unsigned RCF_BIT_POR = 1;
  localparam int unsigned RCF_BIT_BOR = 0;

  localparam logic [7:0] RCF_IMPL_MASK = 8'hdf;
  localparam logic [7:0] RCF_FLAGS_POR = 8'h1c;
  localparam logic [7:0] RCF_PWR_SET = 8'h1c;
  localparam logic [7:0] RCF_POR_CLR = 8'hc3;
  localparam logic [7:0] RCF_BOR_CLR = 8'hc1;
  localparam logic [7:0] RCF_STATUS_RST = 8'h00;
  localparam logic [7:0] RCF_MASK_RST = 8'h00;

  // One-cycle reset cause reports from the reset generation sources
  typedef struct packed {
    logic stk_ovf;
    logic stk_unf;
    logic wdt;
    logic ext_pin;
    logic instr;
    logic por;
    logic bor;
  } rcf_cause_t;

  typedef enum logic [1:0] {
    RCF_IDLE = 2'b00,
    RCF_ANSWER = 2'b01
  } rcf_apb_state_t;

endpackage : rcf_pkg

// File: hdl/rcf_event_irq.sv
// Sticky event status, mask and level interrupt for the reset cause events
`timescale 1ns/1ps
module rcf_event_irq
  import rcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] event_set,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] status_q,
  output logic [7:0] mask_q,
  output logic irq_q
);

  logic [7:0] status_d;
  logic [7:0] mask_d;
  logic irq_d;

  // Set wins over a write-one clear in the same cycle
  assign status_d = ((status_wr ? (status_q & ~wdata) : status_q) | event_set) & RCF_IMPL_MASK;
  assign mask_d = mask_wr ? (wdata & RCF_IMPL_MASK) : mask_q;
  assign irq_d = |(status_d & mask_d);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= RCF_STATUS_RST;
      mask_q <= RCF_MASK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  property p_event_sticks;
    @(posedge pclk) disable iff (!presetn)
    (event_set != 8'h00) |=> ((status_q & $past(event_set)) == $past(event_set));
  endproperty
  a_event_sticks: assert property (p_event_sticks)
    else $error("raised event not latched in status");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (irq_q == (|(status_q & mask_q)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with status and mask");

endmodule : rcf_event_irq

// File: hdl/rcf_reset_cause_flags.sv
// Reset cause flag register with APB slave, event status and interrupt
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module rcf_reset_cause_flags
  import rcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rcf_cause_t cause,
  input wire logic stack_reset_enable,
  output logic [7:0] reset_cause_flags,
  output logic irq
);

  rcf_apb_state_t state_q;
  rcf_apb_state_t state_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic irq_q;

  // APB decode; one wait state so every answer comes from a flop
  wire logic access_req = psel && penable;
  wire logic access_done = access_req && (state_q == RCF_ANSWER);
  wire logic hit_flags = (paddr == RCF_OFS_FLAGS);
  wire logic hit_status = (paddr == RCF_OFS_STATUS);
  wire logic hit_mask = (paddr == RCF_OFS_MASK);
  wire logic hit_any = hit_flags || hit_status || hit_mask;
  wire logic lane0 = pstrb[0];
  wire logic wr_ok = access_done && pwrite && hit_any && lane0;
  wire logic flags_wr = wr_ok && hit_flags;
  wire logic status_wr = wr_ok && hit_status;
  wire logic mask_wr = wr_ok && hit_mask;
  wire logic [7:0] wbyte = pwdata[7:0];

  wire logic [7:0] rd_byte = hit_flags ? flags_q :
                             hit_status ? status_q :
                             hit_mask ? mask_q : 8'h00;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RCF_IDLE:
      begin
        if (access_req)
        begin
          state_d = RCF_ANSWER;
        end
      end
      RCF_ANSWER:
      begin
        state_d = RCF_IDLE;
      end
      default:
      begin
        state_d = RCF_IDLE;
      end
    endcase
  end

  // Read data and error are captured as pready rises
  wire logic answer_load = access_req && (state_q == RCF_IDLE);
  assign prdata_d = answer_load ? {24'h000000, (hit_any && !pwrite) ? rd_byte : 8'h00} : 32'h00000000;
  assign pslverr_d = answer_load && !hit_any;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= RCF_IDLE;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Cause decode
  wire logic pwr_event = cause.por || cause.bor;
  wire logic stk_ovf_hit = cause.stk_ovf && stack_reset_enable;
  wire logic stk_unf_hit = cause.stk_unf && stack_reset_enable;

  // Power events override every single-cause report of the same cycle
  wire logic [7:0] pwr_set = pwr_event ? RCF_PWR_SET : 8'h00;
  wire logic [7:0] pwr_clr = cause.por ? RCF_POR_CLR : (cause.bor ? RCF_BOR_CLR : 8'h00);

  wire logic [7:0] one_set = pwr_event ? 8'h00 :
                             {stk_ovf_hit, stk_unf_hit, 6'h00};
  wire logic [7:0] one_clr = pwr_event ? 8'h00 :
                             {3'h0, cause.wdt, cause.ext_pin, cause.instr, 2'h0};

  wire logic [7:0] hw_set = pwr_set | one_set;
  wire logic [7:0] hw_clr = pwr_clr | one_clr;

  wire logic [7:0] event_set = {stk_ovf_hit, stk_unf_hit, 1'b0, cause.wdt, cause.ext_pin,
                                cause.instr, cause.por, cause.bor & ~cause.por};

  // Hardware beats a firmware write on the same bit; untouched bits hold
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (RCF_IMPL_MASK[gi])
      begin : g_impl
        assign flags_d[gi] = hw_set[gi] ? 1'b1 :
                             hw_clr[gi] ? 1'b0 :
                             flags_wr ? wbyte[gi] :
                             flags_q[gi];
      end
      else
      begin : g_unused
        assign flags_d[gi] = 1'b0;
      end
    end
  endgenerate

  // Reset of this domain stands for the power-on event itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= RCF_FLAGS_POR;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  rcf_event_irq u_event_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(event_set),
    .status_wr(status_wr),
    .mask_wr(mask_wr),
    .wdata(wbyte),
    .status_q(status_q),
    .mask_q(mask_q),
    .irq_q(irq_q)
  );

  assign prdata = prdata_q;
  assign pready = state_q[0];
  assign pslverr = pslverr_q;
  assign reset_cause_flags = flags_q;
  assign irq = irq_q;

  wire logic any_cause = pwr_event || stk_ovf_hit || stk_unf_hit ||
                         cause.wdt || cause.ext_pin || cause.instr;

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (!any_cause && !flags_wr) |=> (flags_q == $past(flags_q));
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags changed with no cause and no write");

  property p_no_self_restore;
    @(posedge pclk) disable iff (!presetn)
    (!flags_wr && !pwr_event) |=> ((flags_q[4:0] & ~$past(flags_q[4:0])) == 5'h00) &&
      ((~flags_q[7:6] & $past(flags_q[7:6])) == 2'h0);
  endproperty
  a_no_self_restore: assert property (p_no_self_restore)
    else $error("flag returned to its inactive level without a write");

  property p_write_store;
    @(posedge pclk) disable iff (!presetn)
    (flags_wr && !any_cause) |=> (flags_q == ($past(wbyte) & RCF_IMPL_MASK));
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("firmware write not stored in flags");

  property p_write_no_irq;
    @(posedge pclk) disable iff (!presetn)
    (flags_wr && !any_cause && (status_q == 8'h00)) |=> (status_q == 8'h00);
  endproperty
  a_write_no_irq: assert property (p_write_no_irq)
    else $error("flag write raised a reset event");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
    (stk_ovf_hit && !pwr_event) |=> flags_q[RCF_BIT_STK_OVF];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("stack overflow did not set bit 7");

  property p_unf;
    @(posedge pclk) disable iff (!presetn)
    (stk_unf_hit && !pwr_event) |=> flags_q[RCF_BIT_STK_UNF];
  endproperty
  a_unf: assert property (p_unf)
    else $error("stack underflow did not set bit 6");

  property p_wdt;
    @(posedge pclk) disable iff (!presetn)
    (cause.wdt && !pwr_event) |=> !flags_q[RCF_BIT_WDT] ##1 (flags_q[RCF_BIT_WDT] == 1'b0 ||
      $past(flags_wr) || $past(pwr_event));
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset did not clear bit 4");

  property p_pin;
    @(posedge pclk) disable iff (!presetn)
    (cause.ext_pin && !pwr_event) |=> !flags_q[RCF_BIT_EXT_PIN];
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset did not clear bit 3");

  property p_instr;
    @(posedge pclk) disable iff (!presetn)
    (cause.instr && !pwr_event) |=> !flags_q[RCF_BIT_INSTR];
  endproperty
  a_instr: assert property (p_instr)
    else $error("reset instruction did not clear bit 2");

  property p_por;
    @(posedge pclk) disable iff (!presetn)
    cause.por |=> (flags_q == RCF_FLAGS_POR);
  endproperty
  a_por: assert property (p_por)
    else $error("power-on event left wrong flag value");

  property p_bor;
    @(posedge pclk) disable iff (!presetn)
    (cause.bor && !cause.por) |=> (flags_q[7:2] == 6'h07) && !flags_q[RCF_BIT_BOR] &&
      (flags_q[RCF_BIT_POR] == $past(flags_q[RCF_BIT_POR]));
  endproperty
  a_bor: assert property (p_bor)
    else $error("brown-out event left wrong flag value");

  property p_stk_gate;
    @(posedge pclk) disable iff (!presetn)
    (!stack_reset_enable && !flags_wr) |=> (flags_q[7:6] & ~$past(flags_q[7:6])) == 2'h0;
  endproperty
  a_stk_gate: assert property (p_stk_gate)
    else $error("stack flag set while stack reset disabled");

  property p_unused;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> !flags_q[RCF_BIT_UNUSED];
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused bit 5 reads 1");

  property p_pwr_init;
    @(posedge pclk) disable iff (!presetn)
    pwr_event |=> (flags_q[7:6] == 2'h0) && (flags_q[4:2] == 3'h7);
  endproperty
  a_pwr_init: assert property (p_pwr_init)
    else $error("power event did not initialise cause flags");

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    (access_req && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("APB answer not given after one wait state");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (access_req && !pready && !hit_any) |=> pslverr && (prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged as error");

  // Firmware loses the race against a report on the same bit
  property p_hw_beats_write;
    @(posedge pclk) disable iff (!presetn)
    (flags_wr && cause.wdt && !pwr_event) |=> !flags_q[RCF_BIT_WDT];
  endproperty
  a_hw_beats_write: assert property (p_hw_beats_write)
    else $error("firmware write overrode a watchdog report");

  property p_stk_keep;
    @(posedge pclk) disable iff (!presetn)
    ((cause.wdt || cause.ext_pin || cause.instr) && !stk_ovf_hit && !stk_unf_hit &&
      !pwr_event && !flags_wr) |=> (flags_q[7:6] == $past(flags_q[7:6]));
  endproperty
  a_stk_keep: assert property (p_stk_keep)
    else $error("single-cause reset disturbed a stack flag");

  property p_low_keep;
    @(posedge pclk) disable iff (!presetn)
    ((stk_ovf_hit || stk_unf_hit) && !pwr_event && !flags_wr && !cause.wdt &&
      !cause.ext_pin && !cause.instr) |=> (flags_q[4:0] == $past(flags_q[4:0]));
  endproperty
  a_low_keep: assert property (p_low_keep)
    else $error("stack reset disturbed a low flag");

  property p_rd_flags;
    @(posedge pclk) disable iff (!presetn)
    (access_req && !pready && !pwrite && hit_flags) |=>
      (prdata == {24'h000000, $past(flags_q)});
  endproperty
  a_rd_flags: assert property (p_rd_flags)
    else $error("flag read returned wrong data");

  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h00000000) && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("read data or error shown outside the answer cycle");

  property p_cov_wdt;
    @(posedge pclk) disable iff (!presetn)
    cause.wdt ##1 flags_wr;
  endproperty
  c_cov_wdt: cover property (p_cov_wdt);

  property p_cov_race;
    @(posedge pclk) disable iff (!presetn)
    flags_wr && any_cause;
  endproperty
  c_cov_race: cover property (p_cov_race);

  property p_cov_irq;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_stk_off;
    @(posedge pclk) disable iff (!presetn)
    cause.stk_ovf && !stack_reset_enable;
  endproperty
  c_cov_stk_off: cover property (p_cov_stk_off);

endmodule : rcf_reset_cause_flags

// File: bench/rcf_cause_src.sv
// Model of the reset generation sources: single-cycle cause reports
`timescale 1ns/1ps
module rcf_cause_src
  import rcf_pkg::*;
(
  input wire logic fire,
  input wire logic [2:0] kind,
  output rcf_cause_t cause
);
  logic [6:0] onehot;

  // One source reports per reset, so never two cause bits at once
  assign onehot = fire ? (7'h01 << kind) : 7'h00;
  assign cause = rcf_cause_t'(onehot);
endmodule : rcf_cause_src

// File: bench/tb_rcf_reset_cause_flags.sv
// Testbench for the reset cause flag register block
`timescale 1ns/1ps
module tb_rcf_reset_cause_flags;
  import rcf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rcf_cause_t cause;
  logic stack_reset_enable = 1'b1;
  logic [7:0] reset_cause_flags;
  logic irq;
  logic fire = 1'b0;
  logic [2:0] kind = 3'h0;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] exp_flags;
  logic [7:0] exp_stat;
  logic [31:0] rd;
  logic err;

  always #50 pclk = ~pclk;

  rcf_reset_cause_flags rcf_reset_cause_flags_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cause(cause), .stack_reset_enable(stack_reset_enable),
    .reset_cause_flags(reset_cause_flags), .irq(irq)
  );

  rcf_cause_src rcf_cause_src_inst (.fire(fire), .kind(kind), .cause(cause));

  task summarize;
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data,
                     input logic [3:0] strb);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, data};
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave however long it takes, up to the bench limit
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      summarize();
    end
  endtask : apb

  task automatic rdchk(input string name, input logic [11:0] addr, input logic [7:0] exp,
                       input logic exp_err);
    apb(1'b0, addr, 8'h00, 4'h0);
    chk(name, {24'h000000, exp}, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask : rdchk

  task automatic pulse(input logic [2:0] k);
    @(posedge pclk);
    fire <= 1'b1;
    kind <= k;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  function automatic logic [7:0] after_cause(input logic [2:0] k, input logic [7:0] cur);
    logic [7:0] nxt;
    nxt = cur;
    case (k)
      3'h6: if (stack_reset_enable) nxt[RCF_BIT_STK_OVF] = 1'b1;
      3'h5: if (stack_reset_enable) nxt[RCF_BIT_STK_UNF] = 1'b1;
      3'h1: nxt = RCF_FLAGS_POR;
      3'h0: nxt = {6'h07, cur[1], 1'b0};
      default: nxt[k] = 1'b0;
    endcase
    return nxt;
  endfunction : after_cause

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("flags_rst", RCF_OFS_FLAGS, RCF_FLAGS_POR, 1'b0);
    rdchk("status_rst", RCF_OFS_STATUS, 8'h00, 1'b0);
    rdchk("mask_rst", RCF_OFS_MASK, 8'h00, 1'b0);
    apb(1'b1, RCF_OFS_FLAGS, 8'hff, 4'h1);
    rdchk("flags_all_set", RCF_OFS_FLAGS, 8'hdf, 1'b0);
    exp_stat = 8'h00;
    for (int en = 1; en >= 0; en--)
      for (int k = 6; k >= 0; k--)
      begin
        stack_reset_enable <= en[0];
        apb(1'b1, RCF_OFS_FLAGS, 8'h1f, 4'h1);
        pulse(k[2:0]);
        exp_flags = after_cause(k[2:0], 8'h1f);
        exp_stat |= (k < 5 || en != 0) ? (8'h01 << ((k >= 5) ? k + 1 : k)) : 8'h00;
        // Idle long enough that a self-clearing flag would show
        repeat (10) @(posedge pclk);
        chk("flags_port", {24'h0, exp_flags}, {24'h0, reset_cause_flags});
        rdchk("flags", RCF_OFS_FLAGS, exp_flags, 1'b0);
        rdchk("status", RCF_OFS_STATUS, exp_stat, 1'b0);
        chk("irq_masked", 32'h0, {31'h0, irq});
      end
    stack_reset_enable <= 1'b1;
    apb(1'b1, RCF_OFS_STATUS, 8'hff, 4'h1);
    rdchk("status_w1c", RCF_OFS_STATUS, 8'h00, 1'b0);
    apb(1'b1, RCF_OFS_MASK, 8'h10, 4'h1);
    rdchk("mask", RCF_OFS_MASK, 8'h10, 1'b0);
    pulse(3'h4);
    chk("irq_wdt", 32'h1, {31'h0, irq});
    pulse(3'h3);
    apb(1'b1, RCF_OFS_STATUS, 8'h10, 4'h1);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdchk("status_left", RCF_OFS_STATUS, 8'h08, 1'b0);
    apb(1'b1, RCF_OFS_MASK, 8'hff, 4'h1);
    rdchk("mask_all", RCF_OFS_MASK, 8'hdf, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    rdchk("unmapped_rd", 12'h00c, 8'h00, 1'b1);
    apb(1'b1, 12'h00c, 8'h00, 4'h1);
    chk("unmapped_wr", 32'h1, {31'h0, err});
    apb(1'b1, RCF_OFS_FLAGS, 8'h00, 4'h0);
    rdchk("strobe_off", RCF_OFS_FLAGS, 8'h06, 1'b0);
    // Watchdog report lands on the edge that completes the write
    fork
      apb(1'b1, RCF_OFS_FLAGS, 8'hff, 4'h1);
      begin
        repeat (3) @(posedge pclk);
        fire <= 1'b1;
        kind <= 3'h4;
        @(posedge pclk);
        fire <= 1'b0;
      end
    join
    rdchk("hw_beats_wr", RCF_OFS_FLAGS, 8'hcf, 1'b0);
    apb(1'b1, RCF_OFS_FLAGS, 8'h00, 4'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("flags_rerst", RCF_OFS_FLAGS, RCF_FLAGS_POR, 1'b0);
    chk("irq_rerst", 32'h0, {31'h0, irq});
    summarize();
  end
endmodule : tb_rcf_reset_cause_flags
